/* File: dv/conv_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Converter stand-in: one result pulse per request
module conv_model (
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic              go,
	input  wire prox_pkg::thresh_t prox,
	output logic                   convValid,
	output prox_pkg::thresh_t      convProx,
	output prox_pkg::freq_t        convFreq
);
	import prox_pkg::*;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			convValid <= 1'h0;
			convProx  <= 16'h0000;
			convFreq  <= 24'h00_0000;
		end else begin
			convValid <= go;
			// Data only meaningful with the pulse
			convProx  <= go ? prox : ~convProx;
			convFreq  <= go ? {8'h5A, prox} : ~convFreq;
		end
	end
endmodule : conv_model
`default_nettype wire

/* File: dv/proximity_threshold_status_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module proximity_threshold_status_regs_tb;
	import prox_pkg::*;
	typedef struct packed {logic [5:0] i; logic w; byte_t d; byte_t e;} row_t;
	logic        clk_sys = 0, nrst = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
	logic [7:0]  wbAdr = 0;
	logic [31:0] wbDatI = 0, wbDatO;
	logic        ack, convValid, activeMode, pinN, irq, go = 0, oscFault = 0;
	thresh_t     px = 0, convProx;
	freq_t       convFreq;
	byte_t       q;
	int          err_count = 0, checked = 0;
	row_t        rows[12];
	byte_t       codes[5] = '{8'h02, 8'h00, 8'h04, 8'h01, 8'h07};
	logic        pins[5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
	always #2 clk_sys = ~clk_sys;
	proximity_threshold_status_regs DUT (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1),
		.wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(ack), .convValid(convValid),
		.convProx(convProx), .convFreq(convFreq), .oscFault(oscFault),
		.activeMode(activeMode), .interruptOutPin_n(pinN), .irq(irq));
	conv_model PARTNER (.clk_sys(clk_sys), .nrst(nrst), .go(go), .prox(px),
		.convValid(convValid), .convProx(convProx), .convFreq(convFreq));
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt
	task automatic wb(input logic [5:0] i, input logic w, input byte_t d);
		@(posedge clk_sys);
		wbCyc <= 1; wbStb <= 1; wbWe <= w; wbAdr <= {i, 2'h0}; wbDatI <= {24'h00_0000, d};
		// Wait as long as ack takes; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (ack !== 1'h1);
		q = wbDatO[7:0];
		wbCyc <= 0; wbStb <= 0;
	endtask : wb
	task automatic rd(input logic [5:0] i, input byte_t e);
		wb(i, 0, 8'h00);
		`CHK("readback", e, q)
	endtask : rd
	task automatic conv(input thresh_t p);
		@(posedge clk_sys);
		go <= 1; px <= p;
		@(posedge clk_sys);
		go <= 0;
		wt(3);
	endtask : conv
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	initial begin
		#20000;
		err_count++;
		end_sim();
	end
	initial begin
		rows = '{'{6'h08, 1'h0, 8'h00, 8'h00}, '{6'h09, 1'h0, 8'h00, 8'h00},
			'{6'h06, 1'h0, 8'h00, 8'hFF}, '{6'h07, 1'h0, 8'h00, 8'hFF},
			'{6'h0A, 1'h0, 8'h00, 8'h00}, '{6'h0B, 1'h0, 8'h00, 8'h00},
			'{6'h20, 1'h0, 8'h00, 8'h30}, '{6'h0A, 1'h1, 8'hFF, 8'h07},
			'{6'h0B, 1'h1, 8'hFE, 8'h00}, '{6'h3F, 1'h1, 8'hAA, 8'h00},
			'{6'h20, 1'h1, 8'hFF, 8'h30}, '{6'h0A, 1'h1, 8'h00, 8'h00}};
		wt(5);
		nrst <= 1;
		foreach (rows[k]) begin
			if (rows[k].w) wb(rows[k].i, 1, rows[k].d);
			rd(rows[k].i, rows[k].e);
		end
		$display("test table done");
		wb(6'h08, 1, 8'h34);
		rd(6'h08, 8'h00);
		rd(6'h09, 8'h00);
		wb(6'h09, 1, 8'h12);
		rd(6'h08, 8'h34);
		rd(6'h09, 8'h12);
		wb(6'h06, 1, 8'h00);
		wb(6'h07, 1, 8'h01);
		rd(6'h06, 8'h00);
		rd(6'h07, 8'h01);
		$display("test thresholds done");
		conv(16'h0005);
		rd(6'h20, 8'h30);
		`CHK("activeMode", 1'h0, activeMode)
		wb(6'h0B, 1, 8'h01);
		wt(2);
		`CHK("activeMode", 1'h1, activeMode)
		conv(16'h0005);
		rd(6'h20, 8'h70);
		rd(6'h21, 8'h05);
		rd(6'h20, 8'h30);
		conv(16'h0277);
		conv(16'h0345);
		rd(6'h20, 8'h60);
		rd(6'h21, 8'h45);
		conv(16'h0999);
		rd(6'h22, 8'h03);
		rd(6'h23, 8'h45);
		rd(6'h24, 8'h03);
		rd(6'h25, 8'h5A);
		$display("test conversions done");
		for (int k = 0; k < 5; k++) begin
			wb(6'h0A, 1, codes[k]);
			wt(3);
			`CHK("pin", pins[k], pinN)
		end
		// Wake-up mode with the last result above the high threshold
		wb(6'h0A, 1, 8'h01);
		rd(6'h20, 8'h40);
		$display("test pin done");
		wb(6'h31, 1, 8'h80);
		oscFault <= 1;
		wt(4);
		`CHK("irq", 1'h1, irq)
		rd(6'h20, 8'hC0);
		wb(6'h30, 1, 8'h80);
		wb(6'h31, 1, 8'h00);
		wt(3);
		`CHK("irq", 1'h0, irq)
		oscFault <= 0;
		wt(2);
		oscFault <= 1;
		wt(4);
		`CHK("irq", 1'h0, irq)
		wb(6'h31, 1, 8'h80);
		wt(3);
		`CHK("irq", 1'h1, irq)
		$display("test interrupt done");
		// Mid-run reset brings outputs and all but the result registers back to idle
		nrst <= 0;
		wt(2);
		`CHK("activeMode", 1'h0, activeMode)
		`CHK("pin", 1'h1, pinN)
		`CHK("irq", 1'h0, irq)
		nrst <= 1;
		rd(6'h09, 8'h00);
		rd(6'h07, 8'hFF);
		rd(6'h20, 8'hB0);
		$display("test reset done");
		end_sim();
	end
endmodule : proximity_threshold_status_regs_tb
`default_nettype wire

/* File: rtl/prox_pkg.sv */
package prox_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] thresh_t;
	typedef logic [23:0] freq_t;
	typedef logic [3:0]  flags_t;
endpackage : prox_pkg

/* File: rtl/prox_regs.svh */
`ifndef PROX_REGS_SVH
`define PROX_REGS_SVH

// Register indices; byte address is four times the index
`define PROX_IDX_THR_HI_LO  6'h06
`define PROX_IDX_THR_HI_HI  6'h07
`define PROX_IDX_THR_LO_LO  6'h08
`define PROX_IDX_THR_LO_HI  6'h09
`define PROX_IDX_PIN_FUNC   6'h0A
`define PROX_IDX_POWER      6'h0B
`define PROX_IDX_STATUS     6'h20
`define PROX_IDX_PROX_LO    6'h21
`define PROX_IDX_PROX_HI    6'h22
`define PROX_IDX_FREQ_LO    6'h23
`define PROX_IDX_FREQ_MID   6'h24
`define PROX_IDX_FREQ_HI    6'h25
`define PROX_IDX_IRQ_STAT   6'h30
`define PROX_IDX_IRQ_MASK   6'h31

// Reset values
`define PROX_RST_THR_HIGH   16'hFFFF
`define PROX_RST_THR_LOW    16'h0000
`define PROX_RST_PIN_FUNC   3'h0
`define PROX_RST_POWER      1'b0
`define PROX_RST_STAT_PREV  4'h3
`define PROX_RST_IRQ        4'h0

// Pin function codes
`define PROX_PIN_DRDY       3'h4
`define PROX_PIN_COMP       3'h2
`define PROX_PIN_WAKE       3'h1
`define PROX_PIN_OFF        3'h0

// Status field positions inside the status byte
`define PROX_STAT_LSB       4
`define PROX_STAT_MSB       7

`endif

/* File: rtl/proximity_threshold_status_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "prox_regs.svh"
module proximity_threshold_status_regs (
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic [31:0]             wb_dat_o,
	output logic                    wb_ack_o,
	input  wire logic               convValid,
	input  wire prox_pkg::thresh_t  convProx,
	input  wire prox_pkg::freq_t    convFreq,
	input  wire logic               oscFault,
	output logic                    activeMode,
	output logic                    interruptOutPin_n,
	output logic                    irq
);
	import prox_pkg::*;

	logic [5:0] idx;
	logic       req;
	logic       rdReq;
	logic       wrByte;
	byte_t      wrData;
	byte_t      thrHighBuf;
	byte_t      thrLowBuf;
	thresh_t    thrHigh;
	thresh_t    thrLow;
	logic [2:0] pinFunc;
	logic       convTake;
	thresh_t    pendProx;
	freq_t      pendFreq;
	thresh_t    proxResult;
	freq_t      freqResult;
	logic       proxRead;
	logic       dataReady;
	logic       aboveHigh;
	logic       compFlag;
	logic       wakeBit;
	flags_t     stat;
	flags_t     statPrev;
	flags_t     evt;
	flags_t     irqStat;
	flags_t     irqMask;
	byte_t      next_rdData;

	function automatic logic regWrite(input logic wr, input logic [5:0] a, input logic [5:0] r);
		return wr && (a == r);
	endfunction : regWrite

	assign idx      = wb_adr_i[7:2];
	assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rdReq    = req && !wb_we_i;
	assign wrByte   = req && wb_we_i && wb_sel_i[0];
	assign wrData   = wb_dat_i[7:0];
	assign convTake = convValid && activeMode;
	assign proxRead = rdReq && (idx == `PROX_IDX_PROX_LO);

	// host ordering relied on, buffer then commit
	threshold_pair #(.RESET_VALUE(`PROX_RST_THR_HIGH)) uThrHigh (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.wrLo     (regWrite(wrByte, idx, `PROX_IDX_THR_HI_LO)),
		.wrHi     (regWrite(wrByte, idx, `PROX_IDX_THR_HI_HI)),
		.wrData   (wrData),
		.loBuffer (thrHighBuf),
		.active   (thrHigh)
	);

	threshold_pair #(.RESET_VALUE(`PROX_RST_THR_LOW)) uThrLow (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.wrLo     (regWrite(wrByte, idx, `PROX_IDX_THR_LO_LO)),
		.wrHi     (regWrite(wrByte, idx, `PROX_IDX_THR_LO_HI)),
		.wrData   (wrData),
		.loBuffer (thrLowBuf),
		.active   (thrLow)
	);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pinFunc    <= `PROX_RST_PIN_FUNC;
			activeMode <= `PROX_RST_POWER;
		end else begin
			if (regWrite(wrByte, idx, `PROX_IDX_PIN_FUNC)) begin
				pinFunc <= wrData[2:0];
			end
			if (regWrite(wrByte, idx, `PROX_IDX_POWER)) begin
				activeMode <= wrData[0];
			end
		end
	end

	// Latest conversion waits here until the host asks for it
	always_ff @(posedge clk_sys) begin
		if (convTake) begin
			pendProx <= convProx;
			pendFreq <= convFreq;
		end
	end

	// copy only when low-byte read starts
	always_ff @(posedge clk_sys) begin
		if (proxRead) begin
			proxResult <= pendProx;
			freqResult <= pendFreq;
		end
	end

	// new conversion wins over the clearing read
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dataReady <= 1'b0;
		end else if (convTake) begin
			dataReady <= 1'b1;
		end else if (proxRead) begin
			dataReady <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			aboveHigh <= 1'b0;
			compFlag  <= 1'b1;
		end else if (convTake) begin
			aboveHigh <= convProx > thrHigh;
			if (convProx > thrHigh) begin
				compFlag <= 1'b0;
			end else if (convProx < thrLow) begin
				compFlag <= 1'b1;
			end
		end
	end

	// low only when wake-up enabled and tripped
	assign wakeBit = !((pinFunc == `PROX_PIN_WAKE) && aboveHigh);
	assign stat    = {oscFault, dataReady, wakeBit, compFlag};
	assign evt     = {stat[3] && !statPrev[3], stat[2] && !statPrev[2],
	                  !stat[1] && statPrev[1], stat[0] != statPrev[0]};

	// Sticky events, set beats write-one-to-clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			statPrev <= `PROX_RST_STAT_PREV;
			irqStat  <= `PROX_RST_IRQ;
			irqMask  <= `PROX_RST_IRQ;
			irq      <= 1'b0;
		end else begin
			statPrev <= stat;
			if (regWrite(wrByte, idx, `PROX_IDX_IRQ_STAT)) begin
				irqStat <= (irqStat & ~wrData[`PROX_STAT_MSB:`PROX_STAT_LSB]) | evt;
			end else begin
				irqStat <= irqStat | evt;
			end
			if (regWrite(wrByte, idx, `PROX_IDX_IRQ_MASK)) begin
				irqMask <= wrData[`PROX_STAT_MSB:`PROX_STAT_LSB];
			end
			irq <= |(irqStat & irqMask);
		end
	end

	// pin function select, active low pin
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			interruptOutPin_n <= 1'b1;
		end else begin
			case (pinFunc)
				`PROX_PIN_DRDY: interruptOutPin_n <= !dataReady;
				`PROX_PIN_COMP: interruptOutPin_n <= compFlag;
				`PROX_PIN_WAKE: interruptOutPin_n <= wakeBit;
				default:        interruptOutPin_n <= 1'b1;
			endcase
		end
	end

	always_comb begin
		next_rdData = 8'h00;
		unique case (idx)
			// buffer location reads active low byte
			`PROX_IDX_THR_HI_LO: next_rdData = thrHigh[7:0];
			`PROX_IDX_THR_HI_HI: next_rdData = thrHigh[15:8];
			`PROX_IDX_THR_LO_LO: next_rdData = thrLow[7:0];
			`PROX_IDX_THR_LO_HI: next_rdData = thrLow[15:8];
			`PROX_IDX_PIN_FUNC:  next_rdData = {5'h00, pinFunc};
			`PROX_IDX_POWER:     next_rdData = {7'h00, activeMode};
			`PROX_IDX_STATUS:    next_rdData = {stat, 4'h0};
			// fresh copy seen by the same read
			`PROX_IDX_PROX_LO:   next_rdData = pendProx[7:0];
			`PROX_IDX_PROX_HI:   next_rdData = proxResult[15:8];
			`PROX_IDX_FREQ_LO:   next_rdData = freqResult[7:0];
			`PROX_IDX_FREQ_MID:  next_rdData = freqResult[15:8];
			`PROX_IDX_FREQ_HI:   next_rdData = freqResult[23:16];
			`PROX_IDX_IRQ_STAT:  next_rdData = {irqStat, 4'h0};
			`PROX_IDX_IRQ_MASK:  next_rdData = {irqMask, 4'h0};
			default:             next_rdData = 8'h00;
		endcase
	end

	// Single-wait-state slave, every address acknowledged
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (rdReq) begin
				wb_dat_o <= {24'h00_0000, next_rdData};
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence s_proxRead;
		rdReq && (idx == `PROX_IDX_PROX_LO);
	endsequence
	sequence s_copyDone;
		(proxResult == $past(pendProx)) && (freqResult == $past(pendFreq));
	endsequence

	a_ack_single_pulse: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse after request");
	a_lo_buffer_read: assert property (
		rdReq && (idx == `PROX_IDX_THR_LO_LO) |=> wb_dat_o[7:0] == $past(thrLow[7:0]))
		else $error("low byte read not the active threshold");
	a_commit_both: assert property (
		regWrite(wrByte, idx, `PROX_IDX_THR_LO_HI)
		|=> thrLow == {$past(wrData), $past(thrLowBuf)})
		else $error("high byte write did not commit both bytes");
	a_hi_byte_read: assert property (
		rdReq && (idx == `PROX_IDX_THR_LO_HI) |=> wb_dat_o == {24'h00_0000, $past(thrLow[15:8])})
		else $error("high byte read wrong");
	a_pin_drdy: assert property (
		(pinFunc == `PROX_PIN_DRDY) |=> interruptOutPin_n == !$past(dataReady))
		else $error("pin not following result ready");
	a_standby_hold: assert property (
		convValid && !activeMode |=> $stable(pendProx))
		else $error("conversion accepted in standby");
	a_oscillator_fault_flag: assert property (
		rdReq && (idx == `PROX_IDX_STATUS) |=> wb_dat_o[7] == $past(oscFault))
		else $error("oscillator flag wrong");
	a_ready_set: assert property (
		convTake |=> dataReady ##0 stat[2])
		else $error("result ready not set");
	a_wake_off: assert property (
		rdReq && (idx == `PROX_IDX_STATUS) && (pinFunc != `PROX_PIN_WAKE) |=> wb_dat_o[5])
		else $error("wake bit low while disabled");
	a_comp_above: assert property (
		convTake && (convProx > thrHigh) |=> !compFlag)
		else $error("comparator not cleared above high");
	a_copy_on_read: assert property (
		s_proxRead |=> s_copyDone)
		else $error("result not copied on read");
	a_no_copy: assert property (
		!proxRead |=> $stable(proxResult) && $stable(freqResult))
		else $error("result changed without read");
	a_power_reserved: assert property (
		rdReq && (idx == `PROX_IDX_POWER) |=> wb_dat_o[31:1] == 31'h0000_0000)
		else $error("reserved power bits not zero");
	a_irq_set_wins: assert property (
		evt[2] |=> irqStat[2])
		else $error("event lost against clear");
endmodule : proximity_threshold_status_regs
`default_nettype wire

/* File: rtl/threshold_pair.sv */
`timescale 1ns/100ps
`default_nettype none
// Byte buffer plus 16-bit active threshold committed by the high byte
module threshold_pair #(
	parameter prox_pkg::thresh_t RESET_VALUE = 16'h0000
) (
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic              wrLo,
	input  wire logic              wrHi,
	input  wire prox_pkg::byte_t   wrData,
	output prox_pkg::byte_t        loBuffer,
	output prox_pkg::thresh_t      active
);
	import prox_pkg::*;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			loBuffer <= RESET_VALUE[7:0];
		end else if (wrLo) begin
			loBuffer <= wrData;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			active <= RESET_VALUE;
		end else if (wrHi) begin
			active <= {wrData, loBuffer};
		end
	end
endmodule : threshold_pair
`default_nettype wire
